// ### fpk_consts.vh
// constants for the front panel key and indicator block
`ifndef FPK_CONSTS_VH
`define FPK_CONSTS_VH

// ==========================================================
// timing
`define FPK_CLK_HZ       10000000
`define FPK_HOLD_MS      3000
`define FPK_SLOW_MS      500
`define FPK_FAST_MS      100
`define FPK_MS_CYC(ms)   ((ms) * (`FPK_CLK_HZ / 1000))

// ==========================================================
// register offsets
`define FPK_REG_CTRL     8'h00
`define FPK_REG_STATUS   8'h04
`define FPK_REG_VALUE    8'h08
`define FPK_REG_ENTRY    8'h0C
`define FPK_REG_IRQSTAT  8'h10
`define FPK_REG_IRQMASK  8'h14

// ==========================================================
// reset values and fields
`define FPK_CTRL_RST     1'b0
`define FPK_MASK_RST     6'h00
`define FPK_NEV          6
`define FPK_EV_MAXMIN    0
`define FPK_EV_FACTORY   1
`define FPK_EV_LOCK      2
`define FPK_EV_COMMIT    3
`define FPK_EV_REMOTE    4
`define FPK_EV_EXIT      5
`define FPK_MENU_DEPTH   2'h2
`define FPK_MAX_DIGITS   4'h8
`define FPK_RESP_OKAY    2'h0
`define FPK_RESP_SLVERR  2'h2

`endif

// ### fpk_key_hold.v
// press and hold timing for one synchronised key
`timescale 1ns/10ps
`include "fpk_consts.vh"
module fpk_key_hold #(
  parameter [31:0] HOLD_CYC = `FPK_MS_CYC(`FPK_HOLD_MS)
) (
  input  wire ref_clk,
  input  wire rst_n,
  input  wire keyLevel,
  output reg  shortPulse_ff,
  output reg  longPulse_ff
);
  reg [31:0] cnt_ff;
  reg        prev_ff;

  // ==========================================================
  // hold counter, saturates at the threshold
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff        <= 32'h0;
      prev_ff       <= 1'b0;
      shortPulse_ff <= 1'b0;
      longPulse_ff  <= 1'b0;
    end else begin
      prev_ff <= keyLevel;
      if (keyLevel) begin
        if (prev_ff && cnt_ff != HOLD_CYC)
          cnt_ff <= cnt_ff + 32'h1;
        else if (!prev_ff)
          cnt_ff <= 32'h1;
      end
      longPulse_ff  <= keyLevel && prev_ff && (cnt_ff == HOLD_CYC - 32'h1);
      shortPulse_ff <= !keyLevel && prev_ff && (cnt_ff < HOLD_CYC);
    end
  end
endmodule

// ### fpk_blink.v
// free running blink square wave
`timescale 1ns/10ps
module fpk_blink #(
  parameter [31:0] HALF_CYC = 32'd5000000
) (
  input  wire ref_clk,
  input  wire rst_n,
  output reg  blink_ff
);
  reg [31:0] cnt_ff;

  // ==========================================================
  // half period counter
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff   <= 32'h0;
      blink_ff <= 1'b0;
    end else if (cnt_ff >= HALF_CYC - 32'h1) begin
      cnt_ff   <= 32'h0;
      blink_ff <= ~blink_ff;
    end else begin
      cnt_ff <= cnt_ff + 32'h1;
    end
  end
endmodule

// ### fpk_panel.v
// front panel key decoding, menu walk and indicator drive
//
// Function
// - clear key wipes all max/min readings
// - remote/local key toggles remote mode
// - escape cancels entry, goes up, exits
// - escape held 3 s restores defaults
// - enter commits entry or descends menu
// - enter held 3 s toggles keypad lock
// - arrows move highlight and step values
// - pad enters digits, point, sign toggle
// - remote LED steady in remote mode
// - network LED steady when link good
// - network LED slow blink acquiring address
// - network LED fast blink on error
// - alarm LED steady if enabled and visual
// - alarm LED blinks when visual input alarming
// - output LED on only when output on
// - display unit and input letter symbols
// - escape once clears entry, twice leaves
`timescale 1ns/10ps
`include "fpk_consts.vh"
module fpk_panel #(
  parameter [31:0] HOLD_CYC = `FPK_MS_CYC(`FPK_HOLD_MS),
  parameter [31:0] SLOW_CYC = `FPK_MS_CYC(`FPK_SLOW_MS),
  parameter [31:0] FAST_CYC = `FPK_MS_CYC(`FPK_FAST_MS)
) (
  input  wire        ref_clk,
  input  wire        rst_n,
  input  wire [7:0]  awaddr,
  input  wire        awvalid,
  output wire        awready,
  input  wire [31:0] wdata,
  input  wire [3:0]  wstrb,
  input  wire        wvalid,
  output wire        wready,
  output reg  [1:0]  bresp,
  output reg         bvalid,
  input  wire        bready,
  input  wire [7:0]  araddr,
  input  wire        arvalid,
  output wire        arready,
  output reg  [31:0] rdata,
  output reg  [1:0]  rresp,
  output reg         rvalid,
  input  wire        rready,
  input  wire        keyClear,
  input  wire        keyRemote,
  input  wire        keyEsc,
  input  wire        keyEnter,
  input  wire        keyUp,
  input  wire        keyDown,
  input  wire        keySign,
  input  wire        keyPoint,
  input  wire [9:0]  keyDigit,
  input  wire        netLinkUp,
  input  wire        netAcquiring,
  input  wire        netError,
  input  wire [3:0]  alarmEnable,
  input  wire [3:0]  alarmVisual,
  input  wire [3:0]  alarmActive,
  input  wire [3:0]  outOn,
  input  wire [3:0]  outMonitor,
  input  wire [1:0]  rdgInput,
  input  wire [2:0]  rdgUnits,
  output reg         ledRemote_ff,
  output reg         ledNet_ff,
  output reg         ledAlarm_ff,
  output reg  [3:0]  ledOut_ff,
  output reg  [3:0]  symInput_ff,
  output reg  [5:0]  symUnit_ff,
  output reg         clrMaxMin_ff,
  output reg         factoryReset_ff,
  output reg         remoteMode_ff,
  output reg         keyLocked_ff,
  output reg         irq_ff
);
  localparam [3:0] ST_IDLE = 4'b0001;
  localparam [3:0] ST_NAV  = 4'b0010;
  localparam [3:0] ST_NUM  = 4'b0100;
  localparam [3:0] ST_SEL  = 4'b1000;

  function [3:0] digitCode;
    input [9:0] oneHot;
    integer i;
    begin
      digitCode = 4'h0;
      for (i = 0; i < 10; i = i + 1)
        if (oneHot[i])
          digitCode = i[3:0];
    end
  endfunction

  // ==========================================================
  // key synchronisers and press edges
  reg  [17:0] keySync1_ff;
  reg  [17:0] keySync2_ff;
  reg  [17:0] keyPrev_ff;
  wire [17:0] keyPins = {keyClear, keyRemote, keyEsc, keyEnter, keyUp,
                         keyDown, keySign, keyPoint, keyDigit};
  wire [17:0] pressEdge = keySync2_ff & ~keyPrev_ff;

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      keySync1_ff <= 18'h0;
      keySync2_ff <= 18'h0;
      keyPrev_ff  <= 18'h0;
    end else begin
      keySync1_ff <= keyPins;
      keySync2_ff <= keySync1_ff;
      keyPrev_ff  <= keySync2_ff;
    end
  end

  wire escShort;
  wire escLong;
  wire entShort;
  wire entLong;
  wire slowBlink;
  wire fastBlink;

  fpk_key_hold #(.HOLD_CYC(HOLD_CYC)) escHold (
    .ref_clk      (ref_clk),
    .rst_n        (rst_n),
    .keyLevel     (keySync2_ff[15]),
    .shortPulse_ff(escShort),
    .longPulse_ff (escLong)
  );

  fpk_key_hold #(.HOLD_CYC(HOLD_CYC)) entHold (
    .ref_clk      (ref_clk),
    .rst_n        (rst_n),
    .keyLevel     (keySync2_ff[14]),
    .shortPulse_ff(entShort),
    .longPulse_ff (entLong)
  );

  fpk_blink #(.HALF_CYC(SLOW_CYC)) slowGen (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .blink_ff(slowBlink)
  );

  fpk_blink #(.HALF_CYC(FAST_CYC)) fastGen (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .blink_ff(fastBlink)
  );

  // a locked keypad still sees the enter hold, so it can unlock
  wire       act      = !keyLocked_ff;
  wire       pClear   = act && pressEdge[17];
  wire       pRemote  = act && pressEdge[16];
  wire       pUp      = act && pressEdge[13];
  wire       pDown    = act && pressEdge[12];
  wire       pSign    = act && pressEdge[11];
  wire       pPoint   = act && pressEdge[10];
  wire       pDigit   = act && (pressEdge[9:0] != 10'h0);
  wire       pEsc     = act && escShort;
  wire       pEnt     = act && entShort;
  wire       pFactory = act && escLong;

  // ==========================================================
  // menu walk and entry
  reg  [3:0]  state_ff;
  reg  [1:0]  depth_ff;
  reg  [3:0]  highlight_ff;
  reg  [3:0]  selValue_ff;
  reg  [31:0] entryDigits_ff;
  reg  [3:0]  digitCount_ff;
  reg         pointSeen_ff;
  reg  [3:0]  pointPos_ff;
  reg         entryNeg_ff;
  reg  [31:0] commitVal_ff;
  reg         ctrlNumeric_ff;
  reg         commitEv_ff;
  reg         exitEv_ff;
  wire        entryUsed = (digitCount_ff != 4'h0) || pointSeen_ff || entryNeg_ff;

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff       <= ST_IDLE;
      depth_ff       <= 2'h0;
      highlight_ff   <= 4'h0;
      selValue_ff    <= 4'h0;
      entryDigits_ff <= 32'h0;
      digitCount_ff  <= 4'h0;
      pointSeen_ff   <= 1'b0;
      pointPos_ff    <= 4'h0;
      entryNeg_ff    <= 1'b0;
      commitVal_ff   <= 32'h0;
      commitEv_ff    <= 1'b0;
      exitEv_ff      <= 1'b0;
    end else begin
      commitEv_ff <= 1'b0;
      exitEv_ff   <= 1'b0;
      case (state_ff)
        ST_IDLE: begin
          if (pEnt) begin
            state_ff     <= ST_NAV;
            depth_ff     <= 2'h1;
            highlight_ff <= 4'h0;
          end
        end
        ST_NAV: begin
          if (pUp)
            highlight_ff <= highlight_ff - 4'h1;
          else if (pDown)
            highlight_ff <= highlight_ff + 4'h1;
          if (pEnt) begin
            if (depth_ff != `FPK_MENU_DEPTH) begin
              depth_ff     <= depth_ff + 2'h1;
              highlight_ff <= 4'h0;
            end else if (ctrlNumeric_ff) begin
              state_ff       <= ST_NUM;
              entryDigits_ff <= 32'h0;
              digitCount_ff  <= 4'h0;
              pointSeen_ff   <= 1'b0;
              entryNeg_ff    <= 1'b0;
            end else begin
              state_ff    <= ST_SEL;
              selValue_ff <= highlight_ff;
            end
          // up one level, exit at top
          end else if (pEsc) begin
            depth_ff <= depth_ff - 2'h1;
            if (depth_ff == 2'h1) begin
              state_ff <= ST_IDLE;
              exitEv_ff <= 1'b1;
            end
          end
        end
        ST_NUM: begin
          if (pDigit && digitCount_ff != `FPK_MAX_DIGITS) begin
            entryDigits_ff <= {entryDigits_ff[27:0], digitCode(pressEdge[9:0])};
            digitCount_ff  <= digitCount_ff + 4'h1;
          end
          if (pPoint && !pointSeen_ff) begin
            pointSeen_ff <= 1'b1;
            pointPos_ff  <= digitCount_ff;
          end
          if (pSign)
            entryNeg_ff <= ~entryNeg_ff;
          if (pEnt) begin
            commitVal_ff <= entryDigits_ff;
            commitEv_ff  <= 1'b1;
            state_ff     <= ST_NAV;
          end else if (pEsc) begin
            if (entryUsed) begin
              entryDigits_ff <= 32'h0;
              digitCount_ff  <= 4'h0;
              pointSeen_ff   <= 1'b0;
              entryNeg_ff    <= 1'b0;
            end else begin
              state_ff <= ST_NAV;
            end
          end
        end
        ST_SEL: begin
          if (pUp)
            selValue_ff <= selValue_ff + 4'h1;
          else if (pDown)
            selValue_ff <= selValue_ff - 4'h1;
          if (pEnt) begin
            commitVal_ff <= {28'h0, selValue_ff};
            commitEv_ff  <= 1'b1;
            state_ff     <= ST_NAV;
          end else if (pEsc) begin
            state_ff <= ST_NAV;
          end
        end
        default: begin
          state_ff <= ST_IDLE;
          depth_ff <= 2'h0;
        end
      endcase
    end
  end

  // ==========================================================
  // panel modes and action pulses
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      remoteMode_ff   <= 1'b0;
      keyLocked_ff    <= 1'b0;
      clrMaxMin_ff    <= 1'b0;
      factoryReset_ff <= 1'b0;
    end else begin
      if (pRemote)
        remoteMode_ff <= ~remoteMode_ff;
      if (entLong)
        keyLocked_ff <= ~keyLocked_ff;
      clrMaxMin_ff    <= pClear;
      factoryReset_ff <= pFactory;
    end
  end

  // ==========================================================
  // indicators and display symbols
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ledRemote_ff <= 1'b0;
      ledNet_ff    <= 1'b0;
      ledAlarm_ff  <= 1'b0;
      ledOut_ff    <= 4'h0;
      symInput_ff  <= 4'h0;
      symUnit_ff   <= 6'h00;
    end else begin
      ledRemote_ff <= remoteMode_ff;
      if (netError)
        ledNet_ff <= fastBlink;
      else if (netAcquiring)
        ledNet_ff <= slowBlink;
      else
        ledNet_ff <= netLinkUp;
      if ((alarmActive & alarmVisual) != 4'h0)
        ledAlarm_ff <= slowBlink;
      else
        ledAlarm_ff <= ((alarmEnable & alarmVisual) != 4'h0);
      ledOut_ff   <= outOn & ~outMonitor;
      symInput_ff <= 4'h1 << rdgInput;
      symUnit_ff  <= (rdgUnits < 3'h6) ? (6'h01 << rdgUnits) : 6'h00;
    end
  end

  // ==========================================================
  // register slave
  reg  [7:0]        awAddr_ff;
  reg               awHave_ff;
  reg  [31:0]       wData_ff;
  reg  [3:0]        wStrb_ff;
  reg               wHave_ff;
  reg  [`FPK_NEV-1:0] irqStat_ff;
  reg  [`FPK_NEV-1:0] irqMask_ff;
  wire [`FPK_NEV-1:0] events = {exitEv_ff, pRemote, commitEv_ff, entLong, pFactory, pClear};
  wire              doWrite = awHave_ff && wHave_ff && !bvalid;
  wire              doRead  = arvalid && !rvalid;
  wire              statRead = doRead && (araddr == `FPK_REG_IRQSTAT);

  assign awready = !awHave_ff;
  assign wready  = !wHave_ff;
  assign arready = !rvalid;

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      awAddr_ff      <= 8'h00;
      awHave_ff      <= 1'b0;
      wData_ff       <= 32'h0;
      wStrb_ff       <= 4'h0;
      wHave_ff       <= 1'b0;
      bvalid         <= 1'b0;
      bresp          <= `FPK_RESP_OKAY;
      ctrlNumeric_ff <= `FPK_CTRL_RST;
      irqMask_ff     <= `FPK_MASK_RST;
    end else begin
      if (awvalid && !awHave_ff) begin
        awAddr_ff <= awaddr;
        awHave_ff <= 1'b1;
      end
      if (wvalid && !wHave_ff) begin
        wData_ff <= wdata;
        wStrb_ff <= wstrb;
        wHave_ff <= 1'b1;
      end
      if (bvalid && bready)
        bvalid <= 1'b0;
      if (doWrite) begin
        awHave_ff <= 1'b0;
        wHave_ff  <= 1'b0;
        bvalid    <= 1'b1;
        bresp     <= `FPK_RESP_OKAY;
        if (awAddr_ff == `FPK_REG_CTRL) begin
          if (wStrb_ff[0])
            ctrlNumeric_ff <= wData_ff[0];
        end else if (awAddr_ff == `FPK_REG_IRQMASK) begin
          if (wStrb_ff[0])
            irqMask_ff <= wData_ff[`FPK_NEV-1:0];
        end else if (awAddr_ff == `FPK_REG_STATUS || awAddr_ff == `FPK_REG_VALUE ||
                     awAddr_ff == `FPK_REG_ENTRY || awAddr_ff == `FPK_REG_IRQSTAT) begin
          bresp <= `FPK_RESP_OKAY;
        end else begin
          bresp <= `FPK_RESP_SLVERR;
        end
      end
    end
  end

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rvalid     <= 1'b0;
      rdata      <= 32'h0;
      rresp      <= `FPK_RESP_OKAY;
      irqStat_ff <= {`FPK_NEV{1'b0}};
      irq_ff     <= 1'b0;
    end else begin
      if (rvalid && rready)
        rvalid <= 1'b0;
      if (doRead) begin
        rvalid <= 1'b1;
        rresp  <= `FPK_RESP_OKAY;
        if (araddr == `FPK_REG_CTRL)
          rdata <= {31'h0, ctrlNumeric_ff};
        else if (araddr == `FPK_REG_STATUS)
          rdata <= {12'h0, selValue_ff, highlight_ff, 2'h0, depth_ff,
                    state_ff, 2'h0, keyLocked_ff, remoteMode_ff};
        else if (araddr == `FPK_REG_VALUE)
          rdata <= commitVal_ff;
        else if (araddr == `FPK_REG_ENTRY)
          rdata <= {19'h0, entryNeg_ff, pointSeen_ff, pointPos_ff, 3'h0,
                    digitCount_ff};
        else if (araddr == `FPK_REG_IRQSTAT)
          rdata <= {26'h0, irqStat_ff};
        else if (araddr == `FPK_REG_IRQMASK)
          rdata <= {26'h0, irqMask_ff};
        else begin
          rdata <= 32'h0;
          rresp <= `FPK_RESP_SLVERR;
        end
      end
      // read clears, a same cycle event still lands
      irqStat_ff <= (statRead ? {`FPK_NEV{1'b0}} : irqStat_ff) | events;
      irq_ff     <= ((irqStat_ff & irqMask_ff) != {`FPK_NEV{1'b0}});
    end
  end
endmodule

// ### fpk_panel_properties.sv
// assertion checker for the front panel key and indicator ports
`timescale 1ns/10ps
module fpk_panel_properties #(
  parameter [31:0] HOLD_CYC = 32'd20
) (
  input wire       ref_clk,
  input wire       rst_n,
  input wire       keyClear,
  input wire       keyRemote,
  input wire       keyEsc,
  input wire       keyEnter,
  input wire       netLinkUp,
  input wire       netAcquiring,
  input wire       netError,
  input wire [3:0] alarmEnable,
  input wire [3:0] alarmVisual,
  input wire [3:0] alarmActive,
  input wire [3:0] outOn,
  input wire [3:0] outMonitor,
  input wire [1:0] rdgInput,
  input wire [2:0] rdgUnits,
  input wire       ledRemote_ff,
  input wire       ledNet_ff,
  input wire       ledAlarm_ff,
  input wire [3:0] ledOut_ff,
  input wire [3:0] symInput_ff,
  input wire [5:0] symUnit_ff,
  input wire       clrMaxMin_ff,
  input wire       factoryReset_ff,
  input wire       remoteMode_ff,
  input wire       keyLocked_ff
);
  logic [31:0] escCnt_ff;
  logic [31:0] entCnt_ff;
  wire         anyAlarming = |(alarmActive & alarmVisual);
  wire         anyEnabled  = |(alarmEnable & alarmVisual);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // ========
  // hold counters
  // raw pin count leads the synchronised key, so a fair hold always passes
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      escCnt_ff <= 32'h0;
      entCnt_ff <= 32'h0;
    end else begin
      escCnt_ff <= keyEsc ? escCnt_ff + 32'h1 : 32'h0;
      entCnt_ff <= keyEnter ? entCnt_ff + 32'h1 : 32'h0;
    end
  end
  // ========
  // assertions
  a_clear_pulse_follows: assert property ($rose(keyClear) && !keyLocked_ff |->
    ##[2:6] clrMaxMin_ff) else $error("no max/min clear after clear key");
  a_remote_key_toggles: assert property ($rose(keyRemote) && !keyLocked_ff |->
    ##[2:6] $changed(remoteMode_ff)) else $error("remote mode did not toggle");
  a_factory_needs_hold: assert property (factoryReset_ff |->
    escCnt_ff >= HOLD_CYC) else $error("factory reset without full hold");
  a_lock_needs_hold: assert property ($changed(keyLocked_ff) |->
    entCnt_ff >= HOLD_CYC) else $error("lock toggled without full hold");
  a_remote_lamp_level: assert property ($stable(remoteMode_ff)[*3] |->
    ledRemote_ff == remoteMode_ff) else $error("remote lamp wrong");
  a_net_lamp_steady: assert property ((netLinkUp && !netAcquiring && !netError)[*3] |->
    ledNet_ff) else $error("network lamp dark with good link");
  a_net_slow_blink: assert property ((netAcquiring && !netError)[*8] |->
    ##[0:6] $changed(ledNet_ff)) else $error("network lamp not blinking slowly");
  a_net_fast_blink: assert property (netError[*4] |->
    ##[0:3] $changed(ledNet_ff)) else $error("network lamp not blinking fast");
  a_alarm_lamp_steady: assert property ((anyEnabled && !anyAlarming)[*3] |->
    ledAlarm_ff) else $error("alarm lamp dark");
  a_alarm_lamp_blinks: assert property (anyAlarming[*8] |->
    ##[0:6] $changed(ledAlarm_ff)) else $error("alarm lamp not blinking");
  a_output_lamps: assert property (($stable(outOn) && $stable(outMonitor))[*3] |->
    ledOut_ff == (outOn & ~outMonitor)) else $error("output lamps wrong");
  a_unit_symbols: assert property (($stable(rdgInput) && $stable(rdgUnits))[*3] |->
    symInput_ff == (4'h1 << rdgInput) &&
    symUnit_ff == ((rdgUnits > 3'h5) ? 6'h00 : (6'h01 << rdgUnits)))
    else $error("display symbols wrong");
  c_clear: cover property (clrMaxMin_ff);
  c_factory: cover property (factoryReset_ff);
  c_locked: cover property ($rose(keyLocked_ff));
  c_error_blink: cover property (netError && $changed(ledNet_ff));
endmodule

bind fpk_panel fpk_panel_properties #(.HOLD_CYC(HOLD_CYC)) u_fpk_panel_properties (
  .ref_clk, .rst_n, .keyClear, .keyRemote, .keyEsc, .keyEnter, .netLinkUp, .netAcquiring,
  .netError, .alarmEnable, .alarmVisual, .alarmActive, .outOn, .outMonitor, .rdgInput,
  .rdgUnits, .ledRemote_ff, .ledNet_ff, .ledAlarm_ff, .ledOut_ff, .symInput_ff, .symUnit_ff,
  .clrMaxMin_ff, .factoryReset_ff, .remoteMode_ff, .keyLocked_ff
);

// ### fpk_keypad_model.sv
// behavioural front panel keypad pressing keys on command
`timescale 1ns/10ps
module fpk_keypad_model (
  input  wire         ref_clk,
  output logic [17:0] keys
);
  initial keys = 18'h0;
  // ========
  // one key at a time, as a finger would; long gap lets release actions land
  task automatic press(input int idx, input int n);
    @(posedge ref_clk);
    keys[idx] <= 1'b1;
    repeat (n) @(posedge ref_clk);
    keys[idx] <= 1'b0;
    repeat (12) @(posedge ref_clk);
  endtask
endmodule

// ### tb_front_panel_key_and_indicator_logic.sv
// self-checking bench for the front panel key and indicator block
`timescale 1ns/10ps
module tb_front_panel_key_and_indicator_logic;
  localparam [31:0] HOLD = 32'd20;
  logic        ref_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'h0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        netLinkUp = 1'b0, netAcquiring = 1'b0, netError = 1'b0;
  logic [3:0]  alarmEnable = 4'h0, alarmVisual = 4'h0, alarmActive = 4'h0;
  logic [3:0]  outOn = 4'h0, outMonitor = 4'h0;
  logic [1:0]  rdgInput = 2'h0;
  logic [2:0]  rdgUnits = 3'h0;
  wire         awready, wready, bvalid, arready, rvalid;
  wire [1:0]   bresp, rresp;
  wire [31:0]  rdata;
  wire         keyClear, keyRemote, keyEsc, keyEnter, keyUp, keyDown, keySign, keyPoint;
  wire [9:0]   keyDigit;
  wire [17:0]  keys;
  wire         ledRemote_ff, ledNet_ff, ledAlarm_ff, clrMaxMin_ff, factoryReset_ff;
  wire         remoteMode_ff, keyLocked_ff, irq_ff;
  wire [3:0]   ledOut_ff, symInput_ff;
  wire [5:0]   symUnit_ff;
  int          miscompares = 0;
  int          total_checks = 0;
  logic [33:0] rdQ[$];
  logic [1:0]  wrQ[$];
  logic [1:0]  pulseQ[$];
  logic [31:0] seed = 32'd28;
  assign {keyDigit, keyPoint, keySign, keyDown, keyUp, keyEnter, keyEsc, keyRemote, keyClear} = keys;
  always #50 ref_clk = ~ref_clk;

  fpk_keypad_model u_fpk_keypad_model (.ref_clk, .keys);
  fpk_panel #(.HOLD_CYC(HOLD), .SLOW_CYC(32'd4), .FAST_CYC(32'd2)) u_fpk_panel (
    .ref_clk, .rst_n, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .keyClear, .keyRemote, .keyEsc, .keyEnter, .keyUp, .keyDown, .keySign,
    .keyPoint, .keyDigit, .netLinkUp, .netAcquiring, .netError, .alarmEnable,
    .alarmVisual, .alarmActive, .outOn, .outMonitor, .rdgInput, .rdgUnits, .ledRemote_ff,
    .ledNet_ff, .ledAlarm_ff, .ledOut_ff, .symInput_ff, .symUnit_ff, .clrMaxMin_ff,
    .factoryReset_ff, .remoteMode_ff, .keyLocked_ff, .irq_ff
  );
  // ========
  // helpers
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic chkWord(input string nm, input logic [33:0] e, input logic [33:0] g);
    total_checks++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chkFlag(input string nm, input logic [1:0] e, input logic [1:0] g);
    chkWord(nm, {32'h0, e}, {32'h0, g});
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // ========
  // bus master: waits for the answer, never assumes a latency
  task automatic axiWrite(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge ref_clk);
    wrQ.push_back(er);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid && n < 50);
    bready <= 1'b0;
    if (n >= 50) chkFlag("write answer", 2'h1, 2'h0);
  endtask
  task automatic axiRead(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge ref_clk);
    rdQ.push_back({er, d});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (!rvalid && n < 50);
    rready <= 1'b0;
    if (n >= 50) chkFlag("read answer", 2'h1, 2'h0);
  endtask
  // ========
  // result watcher: oldest note against each result seen
  always @(posedge ref_clk) begin
    if (rvalid && rready) begin
      chkWord("read", (rdQ.size() > 0) ? rdQ.pop_front() : 34'h0, {rresp, rdata});
    end
    if (bvalid && bready) begin
      chkFlag("bresp", (wrQ.size() > 0) ? wrQ.pop_front() : 2'h3, bresp);
    end
    if (clrMaxMin_ff || factoryReset_ff) begin
      chkFlag("pulse", (pulseQ.size() > 0) ? pulseQ.pop_front() : 2'h0,
              {factoryReset_ff, clrMaxMin_ff});
    end
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    miscompares++;
    summarize();
  end
  // ========
  // main sequence
  initial begin
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
    axiRead(8'h00, 32'h0, 2'h0);
    axiRead(8'h14, 32'h0, 2'h0);
    axiRead(8'h04, 32'h10, 2'h0);
    axiRead(8'h20, 32'h0, 2'h2);
    axiWrite(8'h20, 32'h1, 2'h2);
    axiWrite(8'h04, 32'hFF, 2'h0);
    axiWrite(8'h14, 32'h3F, 2'h0);
    axiRead(8'h14, 32'h3F, 2'h0);
    pulseQ.push_back(2'h1);
    u_fpk_keypad_model.press(0, 4);
    chkFlag("irq", 2'h1, {1'b0, irq_ff});
    axiRead(8'h10, 32'h01, 2'h0);
    axiRead(8'h10, 32'h00, 2'h0);
    chkFlag("irq", 2'h0, {1'b0, irq_ff});
    u_fpk_keypad_model.press(1, 4);
    axiRead(8'h04, 32'h11, 2'h0);
    u_fpk_keypad_model.press(1, 4);
    axiRead(8'h04, 32'h10, 2'h0);
    axiRead(8'h10, 32'h10, 2'h0);
    pulseQ.push_back(2'h2);
    u_fpk_keypad_model.press(2, HOLD + 10);
    axiRead(8'h10, 32'h02, 2'h0);
    u_fpk_keypad_model.press(3, HOLD + 10);
    axiRead(8'h04, 32'h12, 2'h0);
    // locked pad: clear and remote must do nothing
    u_fpk_keypad_model.press(0, 4);
    u_fpk_keypad_model.press(1, 4);
    axiRead(8'h04, 32'h12, 2'h0);
    u_fpk_keypad_model.press(3, HOLD + 10);
    axiRead(8'h10, 32'h04, 2'h0);
    axiWrite(8'h00, 32'h1, 2'h0);
    repeat (3) u_fpk_keypad_model.press(3, 4);
    u_fpk_keypad_model.press(9, 4);
    u_fpk_keypad_model.press(10, 4);
    axiRead(8'h0C, 32'h2, 2'h0);
    u_fpk_keypad_model.press(2, 4);
    axiRead(8'h0C, 32'h0, 2'h0);
    u_fpk_keypad_model.press(2, 4);
    axiRead(8'h04, 32'h220, 2'h0);
    repeat (2) u_fpk_keypad_model.press(2, 4);
    axiRead(8'h10, 32'h20, 2'h0);
    repeat (3) u_fpk_keypad_model.press(3, 4);
    u_fpk_keypad_model.press(6, 4);
    u_fpk_keypad_model.press(15, 4);
    u_fpk_keypad_model.press(7, 4);
    axiRead(8'h0C, 32'h1881, 2'h0);
    u_fpk_keypad_model.press(6, 4);
    u_fpk_keypad_model.press(3, 4);
    axiRead(8'h08, 32'h7, 2'h0);
    axiRead(8'h10, 32'h08, 2'h0);
    // selection path: highlight down twice, open, step up
    axiWrite(8'h00, 32'h0, 2'h0);
    repeat (2) u_fpk_keypad_model.press(5, 4);
    u_fpk_keypad_model.press(3, 4);
    u_fpk_keypad_model.press(4, 4);
    axiRead(8'h04, 32'h32280, 2'h0);
    u_fpk_keypad_model.press(2, 4);
    axiRead(8'h08, 32'h7, 2'h0);
    repeat (2) u_fpk_keypad_model.press(3, 4);
    axiRead(8'h08, 32'h2, 2'h0);
    // lamps and symbols, judged by the checker
    netLinkUp <= 1'b1;
    repeat (12) @(posedge ref_clk);
    netAcquiring <= 1'b1;
    repeat (20) @(posedge ref_clk);
    netError <= 1'b1;
    alarmEnable <= 4'h5;
    alarmVisual <= 4'h4;
    repeat (20) @(posedge ref_clk);
    alarmActive <= 4'h4;
    for (int i = 0; i < 40; i++) begin
      repeat (5) @(posedge ref_clk);
      seed = xorshift(seed);
      outOn <= seed[3:0];
      outMonitor <= seed[7:4];
      rdgInput <= seed[9:8];
      rdgUnits <= seed[12:10];
    end
    chkFlag("pending pulses", 2'h0, (pulseQ.size() == 0) ? 2'h0 : 2'h1);
    summarize();
  end
endmodule
